// >>> uie_uart_ctl.sv
// Serial receive port with baud generator, interrupt logic and an
// infrared codec in the data path. Assumes a single 200 MHz clock and a
// register master that issues one-cycle read or write strobes.
`timescale 1ns/1ps
`default_nettype none

module uie_uart_ctl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rd_data,
  // Serial pins
  input wire logic uart_txd,
  input wire logic line_rxd,
  output logic line_txd,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } uie_rx_e;

  typedef struct packed {
    logic ren;
    logic baud_readback_select;
    logic rx_data_irq_mask;
    logic infrared_codec_enable;
    logic [15:0] reload;
    logic [15:0] count;
    uie_rx_e rx_st;
    logic [3:0] rx_tick;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic [7:0] rx_buf;
    logic ready;
    logic frame_err;
    logic overrun;
    logic [2:0] irq_stat;
    logic [2:0] irq_en;
    logic [7:0] rdata;
  } uie_ctl_s;

  uie_ctl_s r;
  uie_ctl_s next_r;

  logic tick;
  logic dec_rxd;
  logic ir_active;
  logic rx_line;
  logic rx_byte;
  logic rx_err;
  logic baud_evt;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [15:0] baud_view;

  // ----------------------------------------------------------------
  // Decode helper
  // ----------------------------------------------------------------
  // Strobe and address match; shared so every side effect decodes alike
  function automatic logic reg_hit(input logic strobe, input logic [3:0] a,
                                   input logic [3:0] want);
    return strobe && (a == want);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // Codec in the serial path
  // ----------------------------------------------------------------
  uie_endec uie_endec_i (
    .mclk(mclk),
    .rstn(rstn),
    .enable(r.infrared_codec_enable),
    .tick(tick),
    .uart_txd(uart_txd),
    .dec_rxd(dec_rxd),
    .active(ir_active),
    .line_rxd(line_rxd),
    .line_txd(line_txd)
  );

  // Receiver takes the decoded stream with the codec on, the raw pin with it off; codec counters stay inside
  assign rx_line = r.infrared_codec_enable ? dec_rxd : line_rxd;

  // ----------------------------------------------------------------
  // Baud tick generator
  // ----------------------------------------------------------------
  // One tick per reload+1 clocks; the down-count reaching zero is the tick
  assign tick = (r.count == 16'h0000);

  // Baud interrupts only with the receiver off and live read-back chosen
  assign baud_evt = tick & ~r.ren & r.baud_readback_select;

  // Read-back source for the two baud bytes
  assign baud_view = r.baud_readback_select ? r.count : r.reload;

  // ----------------------------------------------------------------
  // Receiver events
  // ----------------------------------------------------------------
  // Byte and error events fire on the stop-bit sample
  always_comb begin
    rx_byte = 1'b0;
    rx_err = 1'b0;
    if (r.ren && tick && r.rx_st == RX_STOP && r.rx_tick == uie_pkg::RX_LAST_TICK) begin
      if (!rx_line || r.ready) begin
        rx_err = 1'b1;
      end else begin
        rx_byte = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt sources and clears
  // ----------------------------------------------------------------
  // Data mask only gates bytes; errors always reach the status
  always_comb begin
    irq_set = 3'h0;
    irq_set[uie_pkg::IRQ_RX_DATA] = rx_byte & ~r.rx_data_irq_mask;
    irq_set[uie_pkg::IRQ_RX_ERR] = rx_err;
    irq_set[uie_pkg::IRQ_BAUD] = baud_evt;
    irq_clr = 3'h0;
    if (reg_hit(wr_en, addr, uie_pkg::ADDR_IRQ_CLR)) begin
      irq_clr = wr_data[2:0];
    end
  end

  assign irq = |(r.irq_stat & r.irq_en);
  assign rd_data = r.rdata;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;

    // Baud counter; a write to either baud byte also restarts the count
    if (tick) begin
      next_r.count = r.reload;
    end else begin
      next_r.count = r.count - 16'h0001;
    end

    // Receive sequencer, stepped by baud ticks
    if (!r.ren) begin
      next_r.rx_st = RX_IDLE;
    end else if (tick) begin
      case (r.rx_st)
        RX_IDLE: begin
          if (!rx_line) begin
            // Only here is bit timing realigned to the line
            next_r.rx_st = RX_START;
            next_r.rx_tick = 4'h0;
          end
        end
        RX_START: begin
          next_r.rx_tick = r.rx_tick + 4'h1;
          if (r.rx_tick == uie_pkg::RX_MID_TICK) begin
            if (rx_line) begin
              next_r.rx_st = RX_IDLE;
            end else begin
              next_r.rx_tick = 4'h0;
              next_r.rx_bit = 3'h0;
              next_r.rx_st = RX_DATA;
            end
          end
        end
        RX_DATA: begin
          next_r.rx_tick = r.rx_tick + 4'h1;
          if (r.rx_tick == uie_pkg::RX_LAST_TICK) begin
            next_r.rx_sh = {rx_line, r.rx_sh[7:1]};
            next_r.rx_bit = r.rx_bit + 3'h1;
            if (r.rx_bit == 3'h7) begin
              next_r.rx_st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          next_r.rx_tick = r.rx_tick + 4'h1;
          if (r.rx_tick == uie_pkg::RX_LAST_TICK) begin
            next_r.rx_st = RX_IDLE;
          end
        end
        default: begin
          next_r.rx_st = RX_IDLE;
        end
      endcase
    end

    // Register writes
    if (wr_en) begin
      if (addr == uie_pkg::ADDR_CTL0) begin
        next_r.ren = wr_data[uie_pkg::CTL0_REN];
      end else if (addr == uie_pkg::ADDR_CTL1) begin
        next_r.baud_readback_select = wr_data[uie_pkg::CTL1_BAUD_SEL];
        next_r.rx_data_irq_mask = wr_data[uie_pkg::CTL1_RX_MASK];
        next_r.infrared_codec_enable = wr_data[uie_pkg::CTL1_IR_EN];
      end else if (addr == uie_pkg::ADDR_BAUD_HI) begin
        next_r.reload = {wr_data, r.reload[7:0]};
        next_r.count = {wr_data, r.reload[7:0]};
      end else if (addr == uie_pkg::ADDR_BAUD_LO) begin
        next_r.reload = {r.reload[15:8], wr_data};
        next_r.count = {r.reload[15:8], wr_data};
      end else if (addr == uie_pkg::ADDR_IRQ_EN) begin
        next_r.irq_en = wr_data[2:0];
      end
    end

    // Read side effects: data read empties the buffer, status read
    // clears the error flags; a new event in the same cycle still lands
    if (reg_hit(rd_en, addr, uie_pkg::ADDR_RX_DATA)) begin
      next_r.ready = 1'b0;
    end
    if (reg_hit(rd_en, addr, uie_pkg::ADDR_LINE_STAT)) begin
      next_r.frame_err = 1'b0;
      next_r.overrun = 1'b0;
    end
    // Overrun keeps the older byte; the newer one is lost
    if (rx_byte) begin
      next_r.rx_buf = r.rx_sh;
      next_r.ready = 1'b1;
    end
    if (rx_err && !rx_line) begin
      next_r.frame_err = 1'b1;
    end
    if (rx_err && rx_line) begin
      next_r.overrun = 1'b1;
    end

    // Sticky status; set beats a clear in the same cycle
    next_r.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;

    // Read data stand for exactly one cycle after the strobe
    next_r.rdata = 8'h00;
    if (rd_en) begin
      if (addr == uie_pkg::ADDR_CTL0) begin
        next_r.rdata = {7'h00, r.ren};
      end else if (addr == uie_pkg::ADDR_CTL1) begin
        next_r.rdata = {5'h00, r.baud_readback_select, r.rx_data_irq_mask,
                        r.infrared_codec_enable};
      end else if (addr == uie_pkg::ADDR_BAUD_HI) begin
        next_r.rdata = baud_view[15:8];
      end else if (addr == uie_pkg::ADDR_BAUD_LO) begin
        next_r.rdata = baud_view[7:0];
      end else if (addr == uie_pkg::ADDR_RX_DATA) begin
        next_r.rdata = r.rx_buf;
      end else if (addr == uie_pkg::ADDR_LINE_STAT) begin
        next_r.rdata = {4'h0, ir_active, r.overrun, r.frame_err, r.ready};
      end else if (addr == uie_pkg::ADDR_IRQ_STAT) begin
        next_r.rdata = {5'h00, r.irq_stat};
      end else if (addr == uie_pkg::ADDR_IRQ_EN) begin
        next_r.rdata = {5'h00, r.irq_en};
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r <= '{ren: 1'b0, baud_readback_select: 1'b0, rx_data_irq_mask: 1'b0,
             infrared_codec_enable: 1'b0, reload: uie_pkg::RELOAD_RST,
             count: uie_pkg::RELOAD_RST, rx_st: RX_IDLE, rx_tick: 4'h0,
             rx_bit: 3'h0, rx_sh: 8'h00, rx_buf: 8'h00, ready: 1'b0,
             frame_err: 1'b0, overrun: 1'b0, irq_stat: 3'h0,
             irq_en: uie_pkg::IRQ_EN_RST, rdata: 8'h00};
    end else begin
      r <= next_r;
    end
  end

endmodule : uie_uart_ctl

`default_nettype wire

// >>> uie_pkg.sv
// Constants shared by the serial control block and its infrared codec.
// Assumes an 8-bit register port with a 4-bit word address.

package uie_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTL0 = 4'h0;
  localparam logic [3:0] ADDR_CTL1 = 4'h1;
  localparam logic [3:0] ADDR_BAUD_HI = 4'h2;
  localparam logic [3:0] ADDR_BAUD_LO = 4'h3;
  localparam logic [3:0] ADDR_RX_DATA = 4'h4;
  localparam logic [3:0] ADDR_LINE_STAT = 4'h5;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h6;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h7;
  localparam logic [3:0] ADDR_IRQ_EN = 4'h8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL0_REN = 0;
  localparam int CTL1_BAUD_SEL = 2;
  localparam int CTL1_RX_MASK = 1;
  localparam int CTL1_IR_EN = 0;
  localparam int IRQ_RX_DATA = 0;
  localparam int IRQ_RX_ERR = 1;
  localparam int IRQ_BAUD = 2;
  localparam int STAT_READY = 0;
  localparam int STAT_FRAME = 1;
  localparam int STAT_OVERRUN = 2;
  localparam int STAT_IR_ACTIVE = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RELOAD_RST = 16'h0010;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;

  // ----------------------------------------------------------------
  // Timing counts, in baud ticks (16 ticks per bit)
  // ----------------------------------------------------------------
  localparam logic [3:0] RX_MID_TICK = 4'h7;
  localparam logic [3:0] RX_LAST_TICK = 4'hf;
  localparam logic [4:0] IR_WIN_OPEN = 5'h0c;
  localparam logic [4:0] IR_WIN_CLOSE = 5'h18;
  localparam logic [4:0] IR_BIT_TICKS = 5'h10;
  localparam logic [3:0] IR_TX_PULSE = 4'h3;

endpackage : uie_pkg

// >>> uie_endec.sv
// Infrared encoder/decoder: pulse tracking on receive, pulse shaping on
// transmit. Assumes a one-cycle baud tick at 16 ticks per bit.
`timescale 1ns/1ps
`default_nettype none

module uie_endec (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Control
  input wire logic enable,
  input wire logic tick,
  // Serial side
  input wire logic uart_txd,
  output logic dec_rxd,
  output logic active,
  // Line side
  input wire logic line_rxd,
  output logic line_txd
);

  typedef struct packed {
    logic rx_prev;
    logic rx_act;
    logic [4:0] rx_cnt;
    logic dec;
    logic tx_prev;
    logic [3:0] tx_cnt;
    logic tx_out;
  } uie_endec_s;

  uie_endec_s r;
  uie_endec_s next_r;
  logic rx_fall;
  logic tx_fall;

  assign rx_fall = r.rx_prev & ~line_rxd;
  assign tx_fall = r.tx_prev & ~uart_txd;
  assign dec_rxd = r.dec;
  assign active = r.rx_act;
  assign line_txd = r.tx_out;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.rx_prev = line_rxd;
    next_r.tx_prev = uart_txd;
    // Receive tracking; its counter is private, the receiver never sees it
    if (!enable) begin
      next_r.rx_act = 1'b0;
      next_r.rx_cnt = 5'h00;
      next_r.dec = 1'b1;
    end else if (!r.rx_act) begin
      if (rx_fall) begin
        next_r.rx_act = 1'b1;
        next_r.rx_cnt = 5'h00;
        next_r.dec = 1'b0;
      end
    end else if (rx_fall && r.rx_cnt >= uie_pkg::IR_WIN_OPEN) begin
      // Pulse inside -4..+7 ticks of expected time: restart the window
      next_r.rx_cnt = 5'h00;
      next_r.dec = 1'b0;
    end else if (tick) begin
      if (r.rx_cnt == uie_pkg::IR_WIN_CLOSE - 5'h01) begin
        // No pulse in the bit: a one, back to waiting for an edge
        next_r.rx_act = 1'b0;
        next_r.rx_cnt = 5'h00;
        next_r.dec = 1'b1;
      end else begin
        next_r.rx_cnt = r.rx_cnt + 5'h01;
        if (r.rx_cnt + 5'h01 == uie_pkg::IR_BIT_TICKS) begin
          next_r.dec = 1'b1;
        end
      end
    end
    // Transmit: short pulse at the start of each zero bit
    if (tx_fall) begin
      next_r.tx_cnt = 4'h0;
    end else if (tick) begin
      next_r.tx_cnt = r.tx_cnt + 4'h1;
    end
    if (enable) begin
      next_r.tx_out = ~uart_txd & (r.tx_cnt < uie_pkg::IR_TX_PULSE);
    end else begin
      next_r.tx_out = uart_txd;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      r <= '{rx_prev: 1'b1, rx_act: 1'b0, rx_cnt: 5'h00, dec: 1'b1,
             tx_prev: 1'b1, tx_cnt: 4'h0, tx_out: 1'b1};
    end else begin
      r <= next_r;
    end
  end

endmodule : uie_endec

`default_nettype wire

// >>> uie_uart_ctl_checker.sv
// Port-level checker for the serial control block.
// Assumes it is bound to uie_uart_ctl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module uie_uart_ctl_checker (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] rd_data,
  // Pins and interrupt
  input wire logic uart_txd,
  input wire logic line_txd,
  input wire logic irq
);
  // ----
  // Shadow of the writable control state
  // ----
  logic [2:0] ctl1;
  logic [15:0] reload;
  logic [2:0] ien;
  logic [7:0] hi_run;

  // Shadows follow the write strobes; hi_run counts idle cycles with the codec on
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctl1 <= 3'h0;
      reload <= uie_pkg::RELOAD_RST;
      ien <= uie_pkg::IRQ_EN_RST;
      hi_run <= 8'h00;
    end else begin
      if (wr_en && addr == uie_pkg::ADDR_CTL1) ctl1 <= wr_data[2:0];
      if (wr_en && addr == uie_pkg::ADDR_BAUD_HI) reload[15:8] <= wr_data;
      if (wr_en && addr == uie_pkg::ADDR_BAUD_LO) reload[7:0] <= wr_data;
      if (wr_en && addr == uie_pkg::ADDR_IRQ_EN) ien <= wr_data[2:0];
      // Saturates so a long idle line cannot wrap back into the pulse span
      hi_run <= (!ctl1[0] || !uart_txd) ? 8'h00 : hi_run + {7'h0, hi_run != 8'hff};
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  property p_rd_idle;
    !$past(rd_en) |-> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_baud_reload;
    rd_en && addr[3:1] == 3'h1 && !ctl1[2]
      |=> rd_data == ($past(addr[0]) ? $past(reload[7:0]) : $past(reload[15:8]));
  endproperty
  a_baud_reload: assert property (p_baud_reload) else $error("baud reload read");
  property p_baud_live;
    rd_en && addr == uie_pkg::ADDR_BAUD_LO && ctl1[2] && reload[15:8] == 8'h00
      |=> rd_data <= $past(reload[7:0]);
  endproperty
  a_baud_live: assert property (p_baud_live) else $error("live count too big");
  property p_ctl_read;
    rd_en && addr == uie_pkg::ADDR_CTL1 |=> rd_data[2:0] == $past(ctl1);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read back");
  property p_txd_pass;
    !ctl1[0] && !$past(ctl1[0]) |-> line_txd == $past(uart_txd);
  endproperty
  a_txd_pass: assert property (p_txd_pass) else $error("direct transmit path");
  property p_txd_ir_idle;
    hi_run > 8'd100 |-> !line_txd;
  endproperty
  a_txd_ir_idle: assert property (p_txd_ir_idle) else $error("codec idle pulse");
  property p_irq_masked;
    ien == 3'h0 |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("irq with no enable");
  property p_stat_irq;
    rd_en && addr == uie_pkg::ADDR_IRQ_STAT
      |=> ((rd_data[2:0] & $past(ien)) != 3'h0) == $past(irq);
  endproperty
  a_stat_irq: assert property (p_stat_irq) else $error("irq against status");

  c_baud_irq: cover property (rd_en && addr == uie_pkg::ADDR_IRQ_STAT ##1 rd_data[2]);
  c_ir_pulse: cover property (ctl1[0] && line_txd);
  c_masked_irq: cover property (irq && ctl1[1]);
endmodule : uie_uart_ctl_checker
`default_nettype wire

// >>> uie_remote_xcvr.sv
// Remote sender that drives the receive pin, plain or infrared.
// Assumes the port ticks every TICK_CLKS clocks, 16 ticks to a bit.
`timescale 1ns/1ps
`default_nettype none

module uie_remote_xcvr #(
  parameter int TICK_CLKS = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Frame request
  input wire logic go,
  input wire logic ir_mode,
  input wire logic [7:0] data,
  input wire logic stop_bit,
  input wire logic [3:0] jit_bit,
  input wire logic signed [4:0] jit,
  output logic busy,
  // Line side, pulled up when idle
  output logic line_rxd
);
  logic [9:0] frame;
  assign frame = {stop_bit, data, 1'b0};

  // One tick at a time; an infrared zero is a 3-tick low pulse, shiftable
  task automatic send_frame();
    int t;
    int b;
    int s;
    logic v;
    busy <= 1'b1;
    for (t = 0; t < 176; t++) begin
      v = 1'b1;
      for (b = 0; b < 10; b++) begin
        s = 16 * b;
        if (b == jit_bit) s = s + jit;
        if (ir_mode && !frame[b] && t >= s && t < s + 3) v = 1'b0;
        if (!ir_mode && t >= 16 * b && t < 16 * b + 16) v = frame[b];
      end
      line_rxd <= v;
      repeat (TICK_CLKS) @(posedge mclk);
    end
    busy <= 1'b0;
  endtask : send_frame

  initial begin
    busy = 1'b0;
    line_rxd = 1'b1;
  end

  // A request is taken only while no frame is running
  always @(posedge mclk) begin
    if (rstn && go && !busy) send_frame();
  end
endmodule : uie_remote_xcvr
`default_nettype wire

// >>> test_uie_uart_ctl.sv
// Self-checking bench for the serial control block.
// Assumes the checker and the remote sender are compiled first.
`timescale 1ns/1ps
`default_nettype none

bind uie_uart_ctl uie_uart_ctl_checker uie_uart_ctl_checker_i (
  .mclk(mclk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .uart_txd(uart_txd), .line_txd(line_txd),
  .irq(irq)
);

module test_uie_uart_ctl;
  logic mclk, rstn, wr_en, rd_en, uart_txd, line_rxd, line_txd, irq;
  logic go, ir_mode, stop_bit, busy;
  logic [3:0] addr, jit_bit;
  logic [7:0] wr_data, rd_data, data;
  logic signed [4:0] jit;
  int checks, bad_count, m;

  uie_uart_ctl uie_uart_ctl_i (
    .mclk(mclk), .rstn(rstn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .uart_txd(uart_txd), .line_rxd(line_rxd),
    .line_txd(line_txd), .irq(irq)
  );
  // Reload 3 gives a tick every 4 clocks
  uie_remote_xcvr #(.TICK_CLKS(4)) uie_remote_xcvr_i (
    .mclk(mclk), .rstn(rstn), .go(go), .ir_mode(ir_mode), .data(data),
    .stop_bit(stop_bit), .jit_bit(jit_bit), .jit(jit), .busy(busy),
    .line_rxd(line_rxd)
  );

  // ----
  // Bus and compare tasks
  // ----
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask : wr

  // Compares the masked read data in the one cycle it stands
  task automatic rdc(input logic [3:0] a, input logic [7:0] mk, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data & mk, e);
  endtask : rdc

  // Bounded wait, then room for the receiver to finish the stop bit
  task automatic send(input logic irm, input logic [7:0] v, input logic stp);
    int n;
    ir_mode <= irm;
    data <= v;
    stop_bit <= stp;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    @(posedge mclk);
    while (busy && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    repeat (80) @(posedge mclk);
  endtask : send

  task automatic wrap_up();
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Watchdog well beyond the few thousand cycles the tests need
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    wrap_up();
  end

  initial begin
    {rstn, wr_en, rd_en, go, ir_mode, stop_bit} = 6'h00;
    {addr, jit_bit, wr_data, data, jit} = {4'h0, 4'hf, 8'h00, 8'h00, 5'sd0};
    uart_txd = 1'b1;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    rdc(uie_pkg::ADDR_CTL1, 8'hff, 8'h00);
    rdc(uie_pkg::ADDR_BAUD_HI, 8'hff, 8'h00);
    rdc(uie_pkg::ADDR_BAUD_LO, 8'hff, 8'h10);
    rdc(4'hf, 8'hff, 8'h00);
    $display("test reset done");
    wr(uie_pkg::ADDR_IRQ_EN, 8'h07);
    wr(uie_pkg::ADDR_BAUD_HI, 8'h00);
    wr(uie_pkg::ADDR_BAUD_LO, 8'h03);
    wr(uie_pkg::ADDR_IRQ_CLR, 8'h07);
    repeat (40) @(posedge mclk);
    rdc(uie_pkg::ADDR_IRQ_STAT, 8'h04, 8'h00);
    rdc(uie_pkg::ADDR_BAUD_LO, 8'hff, 8'h03);
    wr(uie_pkg::ADDR_CTL1, 8'h04);
    repeat (20) @(posedge mclk);
    rdc(uie_pkg::ADDR_IRQ_STAT, 8'h04, 8'h04);
    chk({7'h0, irq}, 8'h01);
    // Restarting the count makes the live value known: 3, then 2 when read
    wr(uie_pkg::ADDR_BAUD_LO, 8'h03);
    rdc(uie_pkg::ADDR_BAUD_LO, 8'hff, 8'h02);
    wr(uie_pkg::ADDR_CTL0, 8'h01);
    wr(uie_pkg::ADDR_IRQ_CLR, 8'h07);
    repeat (20) @(posedge mclk);
    rdc(uie_pkg::ADDR_IRQ_STAT, 8'h04, 8'h00);
    wr(uie_pkg::ADDR_BAUD_LO, 8'h03);
    rdc(uie_pkg::ADDR_BAUD_LO, 8'hff, 8'h02);
    wr(uie_pkg::ADDR_CTL1, 8'h00);
    rdc(uie_pkg::ADDR_BAUD_LO, 8'hff, 8'h03);
    $display("test baud done");
    // Data mask off then on: good byte, then a frame with a low stop bit
    for (m = 0; m < 2; m++) begin
      wr(uie_pkg::ADDR_CTL1, {6'h00, m[0], 1'b0});
      wr(uie_pkg::ADDR_IRQ_CLR, 8'h07);
      send(1'b0, 8'ha5 ^ {8{m[0]}}, 1'b1);
      rdc(uie_pkg::ADDR_IRQ_STAT, 8'h01, {7'h0, !m[0]});
      rdc(uie_pkg::ADDR_RX_DATA, 8'hff, 8'ha5 ^ {8{m[0]}});
      send(1'b0, 8'h0f, 1'b0);
      rdc(uie_pkg::ADDR_IRQ_STAT, 8'h02, 8'h02);
      rdc(uie_pkg::ADDR_LINE_STAT, 8'h02, 8'h02);
    end
    // Two bytes with no read between: the second is an overrun error
    wr(uie_pkg::ADDR_IRQ_CLR, 8'h07);
    send(1'b0, 8'h3c, 1'b1);
    send(1'b0, 8'hc3, 1'b1);
    rdc(uie_pkg::ADDR_IRQ_STAT, 8'h02, 8'h02);
    rdc(uie_pkg::ADDR_LINE_STAT, 8'h07, 8'h05);
    rdc(uie_pkg::ADDR_RX_DATA, 8'hff, 8'h3c);
    $display("test receive done");
    wr(uie_pkg::ADDR_CTL1, 8'h01);
    send(1'b1, 8'h5a, 1'b1);
    rdc(uie_pkg::ADDR_RX_DATA, 8'hff, 8'h5a);
    rdc(uie_pkg::ADDR_LINE_STAT, 8'h08, 8'h00);
    jit_bit <= 4'h4;
    jit <= -5'sd3;
    send(1'b1, 8'h00, 1'b1);
    rdc(uie_pkg::ADDR_RX_DATA, 8'hff, 8'h00);
    jit <= -5'sd5;
    send(1'b1, 8'h00, 1'b1);
    rdc(uie_pkg::ADDR_RX_DATA, 8'hff, 8'h08);
    jit_bit <= 4'hf;
    $display("test infrared receive done");
    // Transmit: direct copy with the codec off, one short pulse with it on
    for (m = 0; m < 2; m++) begin
      wr(uie_pkg::ADDR_CTL1, {7'h00, m[0]});
      uart_txd <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      chk({7'h0, line_txd}, {7'h0, m[0]});
      repeat (24) @(posedge mclk);
      #1;
      chk({7'h0, line_txd}, 8'h00);
      uart_txd <= 1'b1;
      repeat (80) @(posedge mclk);
    end
    $display("test transmit done");
    wrap_up();
  end
endmodule : test_uie_uart_ctl
`default_nettype wire
